//--- core/mdp_power_ctrl.sv
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps


module mdp_power_ctrl (
    input wire logic clk,
    input wire logic srst,
    input wire logic mclk_pin,
    input wire logic msync_pin,
    input wire logic test_pattern_stream,
    input wire logic [2:0] mode_sel,
    input wire logic [2:0] atten_select,
    input wire logic [mdp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic mdata_out,
    output logic mdata_oe,
    output logic overrange_flag_out,
    output logic overrange_flag_oe,
    output mdp_pkg::mdp_dac_t dac
);

    mdp_pkg::mdp_ctrl_t st_r;
    mdp_pkg::mdp_ctrl_t st_nxt;
    mdp_pkg::mdp_status_t status;
    logic [mdp_pkg::PIN_W-1:0] pin_lvl;
    logic [mdp_pkg::PIN_W-1:0] pin_rise;
    logic [mdp_pkg::PIN_W-1:0] pin_fall;
    logic mclk_rise;
    logic mclk_edge;
    logic [2:0] mode_pins;
    logic [2:0] att_pins;
    logic req;
    logic mod_bit;
    logic mod_ovr;

    // ------------------------------------------------------------
    // Attenuation: six halving steps, codes above 1/64 clamp
    // ------------------------------------------------------------
    function automatic logic [2:0] atten_shift(input logic [2:0] sel);
        atten_shift = (sel > mdp_pkg::ATT_MIN) ? mdp_pkg::ATT_MIN : sel;
    endfunction : atten_shift

    // ------------------------------------------------------------
    // Pin synchronisers and modulator
    // ------------------------------------------------------------
    mdp_pin_sync #(
        .W(mdp_pkg::PIN_W)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .pin_in({atten_select, mode_sel, test_pattern_stream, msync_pin, mclk_pin}),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign mclk_rise = pin_rise[mdp_pkg::PIN_MCLK];
    assign mclk_edge = pin_rise[mdp_pkg::PIN_MCLK] | pin_fall[mdp_pkg::PIN_MCLK];
    assign mode_pins = pin_lvl[mdp_pkg::PIN_MODE_LO +: 3];
    assign att_pins = pin_lvl[mdp_pkg::PIN_ATT_LO +: 3];

    mdp_modulator u_mod (
        .clk(clk),
        .srst(srst),
        .enable(st_r.pwr == mdp_pkg::PWR_RUN),
        .mclk_rise(mclk_rise),
        .msync_lvl(pin_lvl[mdp_pkg::PIN_MSYNC]),
        .sample(st_r.analog_in),
        .bit_out(mod_bit),
        .bit_stb(),
        .overrange(mod_ovr)
    );

    // ------------------------------------------------------------
    // Outputs toward the partner
    // ------------------------------------------------------------
    assign mdata_out = mod_bit;
    assign overrange_flag_out = mod_ovr;
    assign mdata_oe = st_r.out_oe;
    assign overrange_flag_oe = st_r.out_oe;
    assign dac = st_r.dac;
    assign req = avs_read || avs_write;
    assign avs_waitrequest = req && !st_r.ack;
    assign avs_readdata = st_r.rdata;

    assign status = '{
        pwr: st_r.pwr,
        mode: st_r.mode,
        atten: atten_shift(st_r.atten),
        overrange: mod_ovr,
        mod_en: st_r.pwr == mdp_pkg::PWR_RUN
    };

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // Loss-of-clock timer, cleared on either master clock edge
        if (mclk_edge) begin
            st_nxt.loc_cnt = '0;
        end else if (st_r.loc_cnt != mdp_pkg::LOC_LAST) begin
            st_nxt.loc_cnt = st_r.loc_cnt + 1'b1;
        end

        if (mclk_rise) begin
            st_nxt.mode = mode_pins;
            st_nxt.atten = att_pins;
            st_nxt.pwr = (mode_pins == mdp_pkg::MODE_SLEEP) ? mdp_pkg::PWR_SLEEP : mdp_pkg::PWR_RUN;
        end
        if (!mclk_edge && st_r.loc_cnt == mdp_pkg::LOC_LAST) begin
            st_nxt.pwr = mdp_pkg::PWR_DOWN;
        end

        // Test DAC steering; everything off unless running
        st_nxt.dac = '0;
        st_nxt.out_oe = st_nxt.pwr == mdp_pkg::PWR_RUN;
        if (st_nxt.pwr == mdp_pkg::PWR_RUN) begin
            unique case (st_nxt.mode)
                mdp_pkg::MODE_MOD, mdp_pkg::MODE_SLEEP: begin
                    st_nxt.dac.ac_active = 1'b0;
                end
                mdp_pkg::MODE_AC_BOTH: begin
                    st_nxt.dac.prec_en = 1'b1;
                    st_nxt.dac.buf_en = 1'b1;
                    st_nxt.dac.ac_active = 1'b1;
                end
                mdp_pkg::MODE_AC_PREC: begin
                    st_nxt.dac.prec_en = 1'b1;
                    st_nxt.dac.ac_active = 1'b1;
                end
                mdp_pkg::MODE_AC_BUF: begin
                    st_nxt.dac.buf_en = 1'b1;
                    st_nxt.dac.ac_active = 1'b1;
                end
                mdp_pkg::MODE_AC_CM: begin
                    st_nxt.dac.prec_en = 1'b1;
                    st_nxt.dac.buf_en = 1'b1;
                    st_nxt.dac.ac_active = 1'b1;
                    st_nxt.dac.common_mode = 1'b1;
                end
                mdp_pkg::MODE_DC_CM: begin
                    st_nxt.dac.prec_en = 1'b1;
                    st_nxt.dac.buf_en = 1'b1;
                    st_nxt.dac.dc_active = 1'b1;
                    st_nxt.dac.common_mode = 1'b1;
                end
                mdp_pkg::MODE_DC_DIFF: begin
                    st_nxt.dac.prec_en = 1'b1;
                    st_nxt.dac.buf_en = 1'b1;
                    st_nxt.dac.dc_active = 1'b1;
                end
            endcase
            if (st_nxt.dac.ac_active) begin
                // Test stream bit taken on each master clock rise
                st_nxt.dac.drive_bit = mclk_rise ? pin_lvl[mdp_pkg::PIN_TSTREAM] : st_r.dac.drive_bit;
            end else begin
                st_nxt.dac.drive_bit = st_nxt.dac.dc_active && !st_nxt.dac.common_mode;
            end
            if (st_nxt.dac.ac_active || st_nxt.dac.dc_active) begin
                st_nxt.dac.atten_shift = atten_shift(st_nxt.atten);
            end
        end

        // Register bus: one wait cycle, answer on the second edge
        if (req && !st_r.ack) begin
            st_nxt.ack = 1'b1;
            unique case (avs_address)
                mdp_pkg::REG_STATUS: st_nxt.rdata = 32'(status);
                mdp_pkg::REG_ANALOG_IN: st_nxt.rdata = 32'(st_r.analog_in);
                default: st_nxt.rdata = '0;
            endcase
        end else begin
            st_nxt.ack = 1'b0;
            if (st_r.ack && avs_write && avs_address == mdp_pkg::REG_ANALOG_IN) begin
                for (int b = 0; b < 2; b++) begin
                    if (avs_byteenable[b]) begin
                        st_nxt.analog_in[b*8 +: 8] = avs_writedata[b*8 +: 8];
                    end
                end
            end
        end

        if (srst) begin
            st_nxt = '0;
            st_nxt.pwr = mdp_pkg::PWR_DOWN;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_loc_powerdown: assert property (
        (st_r.loc_cnt == mdp_pkg::LOC_LAST && !mclk_edge) |=> st_r.pwr == mdp_pkg::PWR_DOWN)
        else $error("no power down after clock loss");
    chk_pd_hiz: assert property (
        st_r.pwr == mdp_pkg::PWR_DOWN |-> (!mdata_oe && !overrange_flag_oe && dac == '0))
        else $error("output driven in power down");
    chk_reset_pd: assert property (
        $past(srst) |-> st_r.pwr == mdp_pkg::PWR_DOWN)
        else $error("not in power down after reset");
    chk_sleep_hiz: assert property (
        st_r.pwr == mdp_pkg::PWR_SLEEP |-> (!mdata_oe && dac == '0))
        else $error("output driven in sleep");
    chk_mod_only: assert property (
        (st_r.pwr == mdp_pkg::PWR_RUN && st_r.mode == mdp_pkg::MODE_MOD)
        |-> (mdata_oe && !dac.prec_en && !dac.buf_en))
        else $error("test outputs active in modulator mode");
    chk_ac_pairs: assert property (
        (st_r.pwr == mdp_pkg::PWR_RUN && st_r.mode == mdp_pkg::MODE_AC_PREC)
        |-> (dac.prec_en && !dac.buf_en && dac.ac_active))
        else $error("wrong pair enabled in mode 2");
    chk_dc_level: assert property (
        (st_r.pwr == mdp_pkg::PWR_RUN && st_r.mode == mdp_pkg::MODE_DC_DIFF)
        |-> (dac.dc_active && dac.drive_bit && !dac.common_mode))
        else $error("DC differential level missing");
    chk_wake_mode: assert property (
        (st_r.pwr == mdp_pkg::PWR_DOWN && mclk_rise) |=> st_r.pwr != mdp_pkg::PWR_DOWN)
        else $error("clock edge did not wake the device");
    chk_mode_sample: assert property (
        !mclk_rise |=> $stable(st_r.mode))
        else $error("mode changed away from a clock rise");
    chk_bus_answer: assert property (
        (req && !st_r.ack) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");

    // ------------------------------------------------------------
    // Checks: outputs per mode and power state
    // ------------------------------------------------------------
    chk_ac_both: assert property (
        (st_r.pwr == mdp_pkg::PWR_RUN && st_r.mode == mdp_pkg::MODE_AC_BOTH)
        |-> (dac.prec_en && dac.buf_en && dac.ac_active && !dac.common_mode))
        else $error("both pairs not enabled in mode 1");
    chk_ac_buf: assert property (
        (st_r.pwr == mdp_pkg::PWR_RUN && st_r.mode == mdp_pkg::MODE_AC_BUF)
        |-> (!dac.prec_en && dac.buf_en && dac.ac_active))
        else $error("wrong pair enabled in mode 3");
    chk_ac_common: assert property (
        (st_r.pwr == mdp_pkg::PWR_RUN && st_r.mode == mdp_pkg::MODE_AC_CM)
        |-> (dac.ac_active && dac.common_mode && !dac.dc_active && mdata_oe))
        else $error("AC common mode output missing");
    chk_dc_common: assert property (
        (st_r.pwr == mdp_pkg::PWR_RUN && st_r.mode == mdp_pkg::MODE_DC_CM)
        |-> (dac.dc_active && dac.common_mode && !dac.drive_bit && !dac.ac_active))
        else $error("DC common mode level missing");
    chk_atten_step: assert property (
        ((dac.ac_active || dac.dc_active) && st_r.atten <= mdp_pkg::ATT_MIN) |-> dac.atten_shift == st_r.atten)
        else $error("attenuation step not applied");
    chk_tstream_take: assert property (
        (mclk_rise && st_nxt.dac.ac_active) |=> dac.drive_bit == $past(pin_lvl[mdp_pkg::PIN_TSTREAM]))
        else $error("test stream bit not taken at clock rise");
    chk_sleep_mode: assert property (
        (mclk_rise && mode_pins == mdp_pkg::MODE_SLEEP) |=> st_r.pwr == mdp_pkg::PWR_SLEEP)
        else $error("mode 7 did not enter sleep");
    chk_pwr_mode: assert property (
        st_r.pwr == mdp_pkg::PWR_RUN |-> st_r.mode != mdp_pkg::MODE_SLEEP)
        else $error("running with the sleep code selected");
    chk_loc_early: assert property (
        (st_r.pwr != mdp_pkg::PWR_DOWN && st_r.loc_cnt != mdp_pkg::LOC_LAST)
        |=> st_r.pwr != mdp_pkg::PWR_DOWN)
        else $error("power down before the clock loss time");
    chk_run_oe: assert property (
        st_r.pwr == mdp_pkg::PWR_RUN |-> (mdata_oe && overrange_flag_oe))
        else $error("outputs not driven while running");
    chk_idle_mod_off: assert property (
        st_r.pwr != mdp_pkg::PWR_RUN |=> (!mdata_out && !overrange_flag_out))
        else $error("modulator active while not running");

    cov_wake_run: cover property (st_r.pwr == mdp_pkg::PWR_DOWN ##1 st_r.pwr == mdp_pkg::PWR_RUN);
    cov_sleep: cover property (st_r.pwr == mdp_pkg::PWR_SLEEP);
    cov_ac_mode: cover property (dac.ac_active && dac.drive_bit);
    cov_overrange: cover property ($rose(mod_ovr));
    cov_loc_timeout: cover property (st_r.pwr == mdp_pkg::PWR_RUN ##1 st_r.pwr == mdp_pkg::PWR_DOWN);

endmodule : mdp_power_ctrl

//--- core/mdp_pkg.sv
package mdp_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int LOC_TIME_US = 40;
    localparam int LOC_CYC = LOC_TIME_US * CLK_MHZ;
    localparam int LOC_W = 13;
    localparam logic [LOC_W-1:0] LOC_LAST = LOC_W'(LOC_CYC - 1);
    // 2.048 MHz master clock over a 512 kbit/s stream
    localparam int MCLK_PER_BIT = 4;
    localparam int PH_W = 2;
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(MCLK_PER_BIT - 1);
    localparam int RECOVER_MCLK = 32;
    localparam int REC_W = 6;
    localparam logic [REC_W-1:0] REC_LAST = REC_W'(RECOVER_MCLK - 1);

    // ------------------------------------------------------------
    // Modulator input scale
    // ------------------------------------------------------------
    localparam int SAMPLE_W = 16;
    localparam int ACC_W = 18;
    localparam logic signed [SAMPLE_W-1:0] FULL_SCALE = 16'sh6000;
    localparam logic signed [SAMPLE_W-1:0] UNSTABLE_POS = 16'sh64CC;
    localparam logic signed [SAMPLE_W-1:0] UNSTABLE_NEG = -16'sh64CC;

    // ------------------------------------------------------------
    // Mode and attenuation codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_MOD = 3'h0;
    localparam logic [2:0] MODE_AC_BOTH = 3'h1;
    localparam logic [2:0] MODE_AC_PREC = 3'h2;
    localparam logic [2:0] MODE_AC_BUF = 3'h3;
    localparam logic [2:0] MODE_DC_CM = 3'h4;
    localparam logic [2:0] MODE_DC_DIFF = 3'h5;
    localparam logic [2:0] MODE_AC_CM = 3'h6;
    localparam logic [2:0] MODE_SLEEP = 3'h7;
    localparam logic [2:0] ATT_MIN = 3'h6;

    // ------------------------------------------------------------
    // Synchroniser lanes and register map
    // ------------------------------------------------------------
    localparam int PIN_MCLK = 0;
    localparam int PIN_MSYNC = 1;
    localparam int PIN_TSTREAM = 2;
    localparam int PIN_MODE_LO = 3;
    localparam int PIN_ATT_LO = 6;
    localparam int PIN_W = 9;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] REG_ANALOG_IN = 4'h4;

    typedef enum logic [1:0] {PWR_DOWN, PWR_SLEEP, PWR_RUN} mdp_pwr_t;

    typedef struct packed {
        logic prec_en;
        logic buf_en;
        logic ac_active;
        logic dc_active;
        logic common_mode;
        logic drive_bit;
        logic [2:0] atten_shift;
    } mdp_dac_t;

    typedef struct packed {
        mdp_pwr_t pwr;
        logic [2:0] mode;
        logic [2:0] atten;
        logic overrange;
        logic mod_en;
    } mdp_status_t;

    typedef struct packed {
        mdp_pwr_t pwr;
        logic [LOC_W-1:0] loc_cnt;
        logic [2:0] mode;
        logic [2:0] atten;
        mdp_dac_t dac;
        logic out_oe;
        logic [SAMPLE_W-1:0] analog_in;
        logic ack;
        logic [31:0] rdata;
    } mdp_ctrl_t;

endpackage : mdp_pkg

//--- core/mdp_pin_sync.sv
`timescale 1ns/1ps

module mdp_pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } mdp_sync_t;

    mdp_sync_t st_r;
    mdp_sync_t st_nxt;
    logic [W-1:0] agree;

    // ------------------------------------------------------------
    // Three stages; a change counts once stages two and three agree
    // ------------------------------------------------------------
    assign agree = ~(st_r.s2 ^ st_r.s3);
    assign level = st_r.lvl;
    assign rise = agree & st_r.s3 & ~st_r.lvl;
    assign fall = agree & ~st_r.s3 & st_r.lvl;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.lvl = (agree & st_r.s3) | (~agree & st_r.lvl);
        if (srst) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

endmodule : mdp_pin_sync

//--- core/mdp_modulator.sv
`timescale 1ns/1ps

module mdp_modulator (
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic mclk_rise,
    input wire logic msync_lvl,
    input wire logic signed [mdp_pkg::SAMPLE_W-1:0] sample,
    output logic bit_out,
    output logic bit_stb,
    output logic overrange
);

    typedef struct packed {
        logic [mdp_pkg::PH_W-1:0] phase;
        logic signed [mdp_pkg::ACC_W-1:0] acc;
        logic bit_q;
        logic stb;
        logic flag;
        logic [mdp_pkg::REC_W-1:0] rec_cnt;
        logic sync_q;
    } mdp_mod_t;

    mdp_mod_t st_r;
    mdp_mod_t st_nxt;
    logic over;
    logic sync_evt;
    logic signed [mdp_pkg::ACC_W-1:0] fb;
    logic signed [mdp_pkg::ACC_W-1:0] acc_n;

    assign over = (sample > mdp_pkg::UNSTABLE_POS) || (sample < mdp_pkg::UNSTABLE_NEG);
    assign sync_evt = msync_lvl && !st_r.sync_q;
    assign fb = st_r.bit_q ? mdp_pkg::ACC_W'(mdp_pkg::FULL_SCALE) : -mdp_pkg::ACC_W'(mdp_pkg::FULL_SCALE);
    assign acc_n = st_r.acc + mdp_pkg::ACC_W'(sample) - fb;
    assign bit_out = st_r.bit_q;
    assign bit_stb = st_r.stb;
    assign overrange = st_r.flag;

    // ------------------------------------------------------------
    // Loop: runs in its first-order fallback form
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.stb = 1'b0;
        if (mclk_rise) begin
            st_nxt.sync_q = msync_lvl;
            if (sync_evt) begin
                st_nxt.phase = '0;
                st_nxt.acc = '0;
            end else begin
                st_nxt.phase = st_r.phase + 1'b1;
                if (st_r.phase == mdp_pkg::PH_LAST) begin
                    st_nxt.acc = acc_n;
                    st_nxt.bit_q = !acc_n[mdp_pkg::ACC_W-1];
                    st_nxt.stb = 1'b1;
                end
            end
            if (over) begin
                st_nxt.flag = 1'b1;
                st_nxt.rec_cnt = '0;
            end else if (st_r.flag) begin
                if (st_r.rec_cnt == mdp_pkg::REC_LAST) begin
                    st_nxt.flag = 1'b0;
                    st_nxt.rec_cnt = '0;
                end else begin
                    st_nxt.rec_cnt = st_r.rec_cnt + 1'b1;
                end
            end
        end
        if (srst || !enable) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_bit_rate: assert property (
        (enable && mclk_rise && !sync_evt && st_r.phase == mdp_pkg::PH_LAST) |=> bit_stb)
        else $error("bit strobe missing at end of bit period");
    chk_sync_phase: assert property (
        (enable && mclk_rise && sync_evt) |=> (st_r.phase == '0 && st_r.acc == '0))
        else $error("sync edge did not restart the loop");
    chk_ovr_set: assert property (
        (enable && mclk_rise && over) |=> overrange)
        else $error("overrange flag not raised");
    chk_ovr_recover: assert property (
        $fell(overrange) |-> (!$past(enable) || $past(st_r.rec_cnt) == mdp_pkg::REC_LAST))
        else $error("overrange flag cleared too early");

endmodule : mdp_modulator

//--- verification/mdp_filter_model.sv
`timescale 1ns/1ps

module mdp_filter_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic sync_req,
    input wire logic [2:0] mode_req,
    input wire logic [2:0] atten_req,
    output logic mclk,
    output logic msync,
    output logic tstream,
    output logic [2:0] mode_sel,
    output logic [2:0] atten_sel
);
    logic [4:0] cnt_r;

    // ------------------------------------------------------------
    // Master clock, half period of 24 system clocks
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            cnt_r <= 5'h00;
            mclk <= 1'b0;
            msync <= 1'b0;
            tstream <= 1'b0;
            mode_sel <= 3'h7;
            atten_sel <= 3'h0;
        end else if (cnt_r == 5'h17) begin
            cnt_r <= 5'h00;
            // Clock stops only after a falling half, so it rests low
            if (run || mclk) begin
                mclk <= !mclk;
            end
            // Control lines move on the falling half, stable at each rise
            if (mclk) begin
                mode_sel <= mode_req;
                msync <= sync_req;
                atten_sel <= atten_req;
                tstream <= !tstream;
            end
        end else begin
            cnt_r <= cnt_r + 5'h01;
        end
    end
endmodule : mdp_filter_model

//--- verification/modulator_dac_power_mode_control_tb.sv
`timescale 1ns/1ps

module modulator_dac_power_mode_control_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic run = 1'b0;
    logic sync_req = 1'b0;
    logic [2:0] mode_req = 3'h0;
    logic [2:0] atten_req = 3'h0;
    logic mclk, msync, tstream;
    logic [2:0] mode_sel, atten_sel;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, mdata_out, mdata_oe, ovr, ovr_oe;
    mdp_pkg::mdp_dac_t dac;
    logic [63:0] q[$];
    logic [31:0] seed = 32'h1D91;
    int err_count = 0;
    int n_compared = 0;
    logic [4:0] dtab [8] = '{5'h00, 5'h1C, 5'h14, 5'h0C, 5'h1B, 5'h1A, 5'h1D, 5'h00};

    always #5 clk = !clk;

    mdp_filter_model partner (.clk(clk), .srst(srst), .run(run), .sync_req(sync_req),
        .mode_req(mode_req), .atten_req(atten_req),
        .mclk(mclk), .msync(msync), .tstream(tstream), .mode_sel(mode_sel), .atten_sel(atten_sel));

    mdp_power_ctrl dut (.clk(clk), .srst(srst), .mclk_pin(mclk), .msync_pin(msync),
        .test_pattern_stream(tstream), .mode_sel(mode_sel), .atten_select(atten_sel),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .mdata_out(mdata_out), .mdata_oe(mdata_oe),
        .overrange_flag_out(ovr), .overrange_flag_oe(ovr_oe), .dac(dac));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        v = v ^ (v << 5);
        return v;
    endfunction : xs

    function automatic logic [31:0] st(input logic [1:0] p, input logic [2:0] m, input logic [2:0] a,
        input logic o, input logic e);
        return {22'h0, p, m, a, o, e};
    endfunction : st

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        // Hold until an edge sees waitrequest low; the watchdog ends a hang
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        q.push_back({m, e & m});
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic mr(input int n);
        repeat (n) @(posedge mclk);
        repeat (8) @(posedge clk);
    endtask : mr

    task automatic wrap_up;
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // Read data monitor
    // ------------------------------------------------------------
    always @(posedge clk) begin
        logic [63:0] x;
        if (avs_read && avs_waitrequest === 1'b0 && q.size() > 0) begin
            x = q.pop_front();
            chk("readdata", x[31:0], avs_readdata & x[63:32]);
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [2:0] a;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("mdata_oe", 0, mdata_oe);
        chk("dac", 0, dac);
        rd(4'h0, st(2'h0, 0, 0, 0, 0), 32'h301);
        run <= 1'b1;
        for (int m = 0; m < 8; m++) begin
            seed = xs(seed);
            a = seed[2:0];
            mode_req <= 3'(m);
            atten_req <= a;
            mr(3);
            rd(4'h0, st(m == 7 ? 2'h1 : 2'h2, 3'(m), a == 3'h7 ? 3'h6 : a, 0, m != 7),
                m == 7 ? 32'h301 : 32'h3FF);
            chk("mdata_oe", m != 7, mdata_oe);
            chk("flag_oe", m != 7, ovr_oe);
            chk("dac_enables", dtab[m], dac[8:4]);
            if (m > 0 && m < 7)
                chk("atten_shift", a == 3'h7 ? 3'h6 : a, dac.atten_shift);
        end
        mode_req <= 3'h0;
        sync_req <= 1'b1;
        mr(3);
        sync_req <= 1'b0;
        bus(1'b1, 4'h4, 32'h7000);
        mr(3);
        chk("overrange", 1, ovr);
        rd(4'h0, 32'h2, 32'h2);
        seed = xs(seed);
        bus(1'b1, 4'h4, {20'h0, seed[11:0]});
        rd(4'h4, {20'h0, seed[11:0]}, 32'hFFFF);
        rd(4'h8, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, 4'h4, 32'h6000);
        mr(20);
        chk("overrange_hold", 1, ovr);
        chk("mdata_full_pos", 1, mdata_out);
        mr(16);
        chk("overrange_clear", 0, ovr);
        bus(1'b1, 4'h4, 32'hA000);
        mr(20);
        chk("mdata_full_neg", 0, mdata_out);
        mode_req <= 3'h3;
        mr(3);
        while (!mclk) @(posedge clk);
        run <= 1'b0;
        mode_req <= 3'h7;
        atten_req <= 3'h5;
        while (mclk) @(posedge clk);
        repeat (3950) @(posedge clk);
        chk("oe_before_timeout", 1, mdata_oe);
        repeat (150) @(posedge clk);
        chk("oe_timeout", 0, mdata_oe);
        chk("flag_oe_timeout", 0, ovr_oe);
        chk("dac_timeout", 0, dac);
        rd(4'h0, 32'h0, 32'h301);
        mode_req <= 3'h2;
        run <= 1'b1;
        mr(1);
        rd(4'h0, st(2'h1, 0, 0, 0, 0), 32'h301);
        mr(2);
        rd(4'h0, st(2'h2, 3'h2, 0, 0, 1), 32'h3E1);
        chk("dac_wake", dtab[2], dac[8:4]);
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule : modulator_dac_power_mode_control_tb
